/* File: verilog/srpf_defs.svh */
// register offsets, field positions and fixed codes of the payload framer
`ifndef SRPF_DEFS_SVH
`define SRPF_DEFS_SVH

// ======================================================================
// register map (word addresses, one 32-bit word each)
`define SRPF_ADR_CTRL    6'h00
`define SRPF_ADR_ALLOW   6'h01
`define SRPF_ADR_REQ     6'h02
`define SRPF_ADR_STAT    6'h03

// ======================================================================
// reset values
`define SRPF_CTRL_RST    12'h0F0
`define SRPF_ALLOW_RST   9'h1FF

// ======================================================================
// field positions
`define SRPF_CTRL_TXEN   0
`define SRPF_CTRL_RXEN   1
`define SRPF_CTRL_REQ    4
`define SRPF_CTRL_PRIM   8
`define SRPF_CTRL_TYPE   9
`define SRPF_STAT_ERR    16

// ======================================================================
// codes and sizes
`define SRPF_CMR_NONE    3'h7
`define SRPF_REQ_NONE    4'hF
`define SRPF_REQ_MAX     4'h8
`define SRPF_T_IO        3'h1
`define SRPF_T_NOREQ     3'h7
`define SRPF_RATE_SID    4'h9
`define SRPF_CMR_LEN     5'h03
`define SRPF_HF_HDR_LEN  5'h10
`define SRPF_SPECIAL_LEN 12'h038
`define SRPF_BUF_AW      9

`endif

/* File: verilog/srpf_pkg.sv */
// state types of the payload framer
package srpf_pkg;

  typedef enum logic [5:0] {
    SRPF_T_IDLE = 6'b000001,
    SRPF_T_DROP = 6'b000010,
    SRPF_T_HDR  = 6'b000100,
    SRPF_T_DATA = 6'b001000,
    SRPF_T_D0   = 6'b010000,
    SRPF_T_PAD  = 6'b100000
  } srpf_tx_state_type;

  typedef enum logic [5:0] {
    SRPF_R_FILL  = 6'b000001,
    SRPF_R_CLASS = 6'b000010,
    SRPF_R_DEC   = 6'b000100,
    SRPF_R_HREAD = 6'b001000,
    SRPF_R_HDR   = 6'b010000,
    SRPF_R_BITS  = 6'b100000
  } srpf_rx_state_type;

endpackage

/* File: verilog/srpf_buf.sv */
// byte buffer holding one received payload, registered read port
`timescale 1ns/1ps
module srpf_buf (
  input  wire logic       clk_i,
  input  wire logic       ce_i,
  input  wire logic       we_i,
  input  wire logic [8:0] waddr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [8:0] raddr_i,
  output logic      [7:0] rdata_o
);
  logic [7:0] mem [0:511];

  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    if (ce_i) begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule // srpf_buf

/* File: verilog/srpf_framer.sv */
// speech payload framer: compact and header-full packing and parsing
// ======================================================================
// Summary of operation
// - legacy compact speech starts with three request bits
// - request codes map to fixed rates
// - 14.25 and 19.85 requests fall lower
// - request outside allowed set falls lower
// - primary requests never in three-bit field
// - legacy compact data from bit one, bit zero last
// - data bits in sensitivity order
// - zero bits pad compact payload to bytes
// - compact payload has no extra header
// - legacy silence frames sent header-full with request
// - damaged legacy frames are dropped
// - 56-bit payload split by first bit
// - primary 2.8 frame first bit zero
// - request, entries, data, padding in order
// - receiver discards header-full padding bits
// - top bit tells entry from request
// - request byte precedes all entries
// - header-full padded off compact sizes
// - compact rate taken from payload size
// - entry continuation flag chains frames
// - request byte: flag, type, mode
`timescale 1ns/1ps
`include "srpf_defs.svh"
module srpf_framer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        tx_start_i,
  input  wire logic [5:0]  tx_ft_i,
  input  wire logic        tx_bit_i,
  input  wire logic        tx_bit_valid_i,
  input  wire logic        tx_bit_last_i,
  output logic             tx_ready_o,
  output logic      [7:0]  tx_byte_o,
  output logic             tx_byte_valid_o,
  output logic             tx_byte_last_o,
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        rx_byte_valid_i,
  input  wire logic        rx_byte_last_i,
  output logic             rx_ready_o,
  output logic             rx_bit_o,
  output logic             rx_bit_valid_o,
  output logic             rx_frame_start_o,
  output logic             rx_frame_end_o,
  output logic      [5:0]  rx_frame_ft_o,
  output logic      [2:0]  rx_cmr_o,
  output logic             rx_cmr_valid_o
);

  // ====================================================================
  // functions
  function automatic logic [3:0] acs_pick(input logic [3:0] req,
                                          input logic [8:0] allow,
                                          input logic       compact);
    logic [3:0] r;
    r = `SRPF_REQ_NONE;
    for (int i = 0; i < 9; i++) begin
      if (req <= `SRPF_REQ_MAX && i <= int'(req) && allow[i] &&
          !(compact && (i == 3 || i == 6))) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] cmr_code(input logic [3:0] idx);
    case (idx)
      4'h0:    cmr_code = 3'h0;
      4'h1:    cmr_code = 3'h1;
      4'h2:    cmr_code = 3'h2;
      4'h4:    cmr_code = 3'h3;
      4'h5:    cmr_code = 3'h4;
      4'h7:    cmr_code = 3'h5;
      4'h8:    cmr_code = 3'h6;
      default: cmr_code = `SRPF_CMR_NONE;
    endcase
  endfunction

  // {valid, io, rate} of a protected compact size
  function automatic logic [5:0] compact_class(input logic [11:0] n);
    case (n)
      12'h030: compact_class = 6'h2C;
      12'h038: compact_class = 6'h20;
      12'h088: compact_class = 6'h30;
      12'h090: compact_class = 6'h21;
      12'h0A0: compact_class = 6'h22;
      12'h0B8: compact_class = 6'h31;
      12'h0C0: compact_class = 6'h23;
      12'h100: compact_class = 6'h32;
      12'h108: compact_class = 6'h24;
      12'h120: compact_class = 6'h33;
      12'h140: compact_class = 6'h34;
      12'h148: compact_class = 6'h25;
      12'h170: compact_class = 6'h35;
      12'h190: compact_class = 6'h36;
      12'h1D0: compact_class = 6'h37;
      12'h1E0: compact_class = 6'h38;
      12'h1E8: compact_class = 6'h26;
      12'h280: compact_class = 6'h27;
      12'h3C0: compact_class = 6'h28;
      12'h500: compact_class = 6'h29;
      12'h780: compact_class = 6'h2A;
      12'hA00: compact_class = 6'h2B;
      default: compact_class = 6'h00;
    endcase
  endfunction

  // coded frame bits for a frame type; unknown types carry none
  function automatic logic [11:0] ft_bits(input logic io,
                                          input logic [3:0] rate);
    logic [11:0] b;
    b = 12'h000;
    if (io) begin
      case (rate)
        4'h0: b = 12'h084;
        4'h1: b = 12'h0B1;
        4'h2: b = 12'h0FD;
        4'h3: b = 12'h11D;
        4'h4: b = 12'h13D;
        4'h5: b = 12'h16D;
        4'h6: b = 12'h18D;
        4'h7: b = 12'h1CD;
        4'h8: b = 12'h1DD;
        4'h9: b = 12'h028;
        default: b = 12'h000;
      endcase
    end else begin
      case (rate)
        4'h0: b = 12'h038;
        4'h1: b = 12'h090;
        4'h2: b = 12'h0A0;
        4'h3: b = 12'h0C0;
        4'h4: b = 12'h108;
        4'h5: b = 12'h148;
        4'h6: b = 12'h1E8;
        4'h7: b = 12'h280;
        4'h8: b = 12'h3C0;
        4'h9: b = 12'h500;
        4'hA: b = 12'h780;
        4'hB: b = 12'hA00;
        4'hC: b = 12'h030;
        default: b = 12'h000;
      endcase
    end
    return b;
  endfunction

  function automatic logic [31:0] sel_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ====================================================================
  // wishbone slave
  logic [11:0] ctrl_reg;
  logic [8:0]  allow_reg;
  logic [7:0]  drop_cnt_reg;
  logic [7:0]  rx_cnt_reg;
  logic        err_reg;
  logic [7:0]  req_byte_reg;
  logic        req_seen_reg;
  logic        rx_err_evt;

  wire         wb_acc   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire         wb_wr    = wb_acc && wb_we_i;
  wire [5:0]   wb_word  = wb_adr_i[7:2];
  wire         wr_ctrl  = wb_wr && (wb_word == `SRPF_ADR_CTRL);
  wire         wr_allow = wb_wr && (wb_word == `SRPF_ADR_ALLOW);
  wire         wr_stat  = wb_wr && (wb_word == `SRPF_ADR_STAT);
  wire [31:0]  ctrl_wr  = sel_merge({20'h00000, ctrl_reg}, wb_dat_i,
                                    wb_sel_i);
  wire [31:0]  allow_wr = sel_merge({23'h000000, allow_reg}, wb_dat_i,
                                    wb_sel_i);
  // error sticky: a new error in the clearing cycle survives
  wire         err_clr  = wr_stat && wb_sel_i[2] &&
                          wb_dat_i[`SRPF_STAT_ERR];
  wire         err_next = rx_err_evt || (err_reg && !err_clr);
  wire [31:0]  rd_mux   =
    (wb_word == `SRPF_ADR_CTRL)  ? {20'h00000, ctrl_reg} :
    (wb_word == `SRPF_ADR_ALLOW) ? {23'h000000, allow_reg} :
    (wb_word == `SRPF_ADR_REQ)   ? {19'h00000, req_seen_reg,
                                    req_byte_reg, rx_cmr_valid_o,
                                    rx_cmr_o} :
    (wb_word == `SRPF_ADR_STAT)  ? {15'h0000, err_reg, rx_cnt_reg,
                                    drop_cnt_reg} : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h00000000;
      ctrl_reg  <= `SRPF_CTRL_RST;
      allow_reg <= `SRPF_ALLOW_RST;
      err_reg   <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= wb_acc;
      wb_dat_o <= wb_acc ? rd_mux : 32'h00000000;
      err_reg  <= err_next;
      if (wr_ctrl) ctrl_reg <= ctrl_wr[11:0];
      if (wr_allow) allow_reg <= allow_wr[8:0];
    end
  end

  wire       tx_en    = ctrl_reg[`SRPF_CTRL_TXEN];
  wire       rx_en    = ctrl_reg[`SRPF_CTRL_RXEN];
  wire [3:0] req_mode = ctrl_reg[`SRPF_CTRL_REQ +: 4];
  wire       req_prim = ctrl_reg[`SRPF_CTRL_PRIM];
  wire [2:0] req_type = ctrl_reg[`SRPF_CTRL_TYPE +: 3];

  // ====================================================================
  // transmit packer
  srpf_pkg::srpf_tx_state_type tx_state_reg;
  srpf_pkg::srpf_tx_state_type tx_state_next;
  logic [15:0] hdr_reg;
  logic [4:0]  hcnt_reg;
  logic [11:0] bcnt_reg;
  logic [6:0]  sh_reg;
  logic        d0_reg;
  logic        first_reg;
  logic        iocmp_reg;
  logic        hf_reg;
  logic        p28_reg;

  wire       ft_io   = tx_ft_i[5];
  wire       ft_drop = ft_io && !tx_ft_i[4];
  wire       ft_sid  = ft_io && (tx_ft_i[3:0] == `SRPF_RATE_SID);
  wire [3:0] pick_hf = acs_pick(req_mode, allow_reg, 1'b0);
  wire [3:0] pick_c  = acs_pick(req_mode, allow_reg, 1'b1);
  // primary-mode requests leave the three-bit field empty
  wire [2:0] cmr3    = req_prim ? `SRPF_CMR_NONE : cmr_code(pick_c);
  wire [6:0] req_td  = req_prim ? {req_type, req_mode} :
                       (pick_hf == `SRPF_REQ_NONE) ?
                       {`SRPF_T_NOREQ, `SRPF_REQ_NONE} :
                       {`SRPF_T_IO, pick_hf};
  wire       tx_take = tx_bit_valid_i &&
                       (tx_state_reg == srpf_pkg::SRPF_T_DATA);
  wire       hold_d0 = tx_take && iocmp_reg && first_reg;

  logic emit;
  logic emit_bit;
  logic tail;
  always_comb begin
    emit     = 1'b0;
    emit_bit = 1'b0;
    tail     = 1'b0;
    case (tx_state_reg)
      srpf_pkg::SRPF_T_HDR: begin
        emit     = 1'b1;
        emit_bit = hdr_reg[15];
      end
      srpf_pkg::SRPF_T_DATA: begin
        emit     = tx_take && !hold_d0;
        emit_bit = (p28_reg && first_reg) ? 1'b0 : tx_bit_i;
        tail     = tx_bit_last_i && !iocmp_reg;
      end
      srpf_pkg::SRPF_T_D0: begin
        emit     = 1'b1;
        emit_bit = d0_reg;
        tail     = 1'b1;
      end
      srpf_pkg::SRPF_T_PAD: begin
        emit     = 1'b1;
        tail     = 1'b1;
      end
      default: emit = 1'b0;
    endcase
  end

  wire [11:0] bcnt_n   = bcnt_reg + 12'h001;
  // header-full may not land on a compact size, except the 56-bit case
  wire        collide  = hf_reg && compact_class(bcnt_n) != 6'h00 &&
                         (bcnt_n != `SRPF_SPECIAL_LEN);
  wire        done_bit = emit && tail && (bcnt_n[2:0] == 3'h0) &&
                         !collide;
  wire        last_in  = tx_take && tx_bit_last_i;

  always_comb begin
    tx_state_next = tx_state_reg;
    case (tx_state_reg)
      srpf_pkg::SRPF_T_IDLE: begin
        if (tx_start_i && tx_en) begin
          tx_state_next = ft_drop ? srpf_pkg::SRPF_T_DROP :
                          ft_io ? srpf_pkg::SRPF_T_HDR :
                          srpf_pkg::SRPF_T_DATA;
        end
      end
      srpf_pkg::SRPF_T_DROP: begin
        if (tx_bit_valid_i && tx_bit_last_i) begin
          tx_state_next = srpf_pkg::SRPF_T_IDLE;
        end
      end
      srpf_pkg::SRPF_T_HDR: begin
        if (hcnt_reg == 5'h01) tx_state_next = srpf_pkg::SRPF_T_DATA;
      end
      srpf_pkg::SRPF_T_DATA: begin
        if (last_in) begin
          tx_state_next = iocmp_reg ? srpf_pkg::SRPF_T_D0 :
                          done_bit ? srpf_pkg::SRPF_T_IDLE :
                          srpf_pkg::SRPF_T_PAD;
        end
      end
      srpf_pkg::SRPF_T_D0, srpf_pkg::SRPF_T_PAD: begin
        tx_state_next = done_bit ? srpf_pkg::SRPF_T_IDLE :
                        srpf_pkg::SRPF_T_PAD;
      end
      default: tx_state_next = srpf_pkg::SRPF_T_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state_reg    <= srpf_pkg::SRPF_T_IDLE;
      hdr_reg         <= 16'h0000;
      hcnt_reg        <= 5'h00;
      bcnt_reg        <= 12'h000;
      sh_reg          <= 7'h00;
      d0_reg          <= 1'b0;
      first_reg       <= 1'b0;
      iocmp_reg       <= 1'b0;
      hf_reg          <= 1'b0;
      p28_reg         <= 1'b0;
      drop_cnt_reg    <= 8'h00;
      tx_ready_o      <= 1'b0;
      tx_byte_o       <= 8'h00;
      tx_byte_valid_o <= 1'b0;
      tx_byte_last_o  <= 1'b0;
    end else if (ce_i) begin
      tx_state_reg    <= tx_state_next;
      tx_ready_o      <= (tx_state_next == srpf_pkg::SRPF_T_DATA) ||
                         (tx_state_next == srpf_pkg::SRPF_T_DROP);
      tx_byte_valid_o <= emit && (bcnt_n[2:0] == 3'h0);
      tx_byte_last_o  <= done_bit;
      if (tx_state_reg == srpf_pkg::SRPF_T_IDLE && tx_start_i && tx_en) begin
        bcnt_reg  <= 12'h000;
        first_reg <= 1'b1;
        iocmp_reg <= ft_io && !ft_sid;
        hf_reg    <= ft_sid;
        p28_reg   <= !ft_io && (tx_ft_i[3:0] == 4'h0);
        hdr_reg   <= ft_sid ? {1'b1, req_td, 2'h0, tx_ft_i} :
                     {cmr3, 13'h0000};
        hcnt_reg  <= ft_sid ? `SRPF_HF_HDR_LEN : `SRPF_CMR_LEN;
        if (ft_drop) drop_cnt_reg <= drop_cnt_reg + 8'h01;
      end
      if (tx_state_reg == srpf_pkg::SRPF_T_HDR) begin
        hdr_reg  <= {hdr_reg[14:0], 1'b0};
        hcnt_reg <= hcnt_reg - 5'h01;
      end
      if (tx_take) first_reg <= 1'b0;
      if (hold_d0) d0_reg <= tx_bit_i;
      if (emit) begin
        bcnt_reg <= bcnt_n;
        sh_reg   <= {sh_reg[5:0], emit_bit};
        if (bcnt_n[2:0] == 3'h0) tx_byte_o <= {sh_reg, emit_bit};
      end
    end
  end

  // ====================================================================
  // receive parser
  srpf_pkg::srpf_rx_state_type rx_state_reg;
  logic [8:0]  wptr_reg;
  logic        ovf_reg;
  logic [11:0] len_reg;
  logic [8:0]  hptr_reg;
  logic [8:0]  toc_base_reg;
  logic        scan_done_reg;
  logic        more_reg;
  logic [11:0] dptr_reg;
  logic [11:0] pos_reg;
  logic [11:0] endp_reg;
  logic [11:0] d0pos_reg;
  logic        d0f_reg;
  logic        ph_reg;
  logic [7:0]  rd_data;

  wire        rx_take = rx_byte_valid_i && rx_ready_o;
  wire [11:0] cur     = d0f_reg ? d0pos_reg : pos_reg;
  wire [8:0]  rd_addr = (rx_state_reg == srpf_pkg::SRPF_R_HREAD) ? hptr_reg :
                        (rx_state_reg == srpf_pkg::SRPF_R_BITS) ?
                        cur[11:3] : 9'h000;
  wire [5:0]  cls     = compact_class(len_reg);
  wire [11:0] cmp_k   = ft_bits(1'b1, cls[3:0]);
  wire [11:0] toc_len = ft_bits(rd_data[5], rd_data[3:0]);
  wire [11:0] toc_end = dptr_reg + toc_len;
  wire [11:0] hpos    = {hptr_reg, 3'h0};
  wire        hp_out  = hpos >= len_reg;
  wire        bit_end = !d0f_reg && (pos_reg == endp_reg);
  wire        is_p28  = (len_reg == `SRPF_SPECIAL_LEN) && !rd_data[7];
  wire [8:0]  wptr_n  = wptr_reg + 9'h001;

  assign rx_err_evt =
    (rx_take && rx_byte_last_i && ovf_reg) ||
    (rx_state_reg == srpf_pkg::SRPF_R_HDR &&
     (hp_out || (!scan_done_reg && rd_data[7] && hptr_reg != 9'h000) ||
      (scan_done_reg && toc_end > len_reg)));

  srpf_buf u_buf (
    .clk_i   (clk_i),
    .ce_i    (ce_i),
    .we_i    (rx_take && !ovf_reg),
    .waddr_i (wptr_reg),
    .wdata_i (rx_byte_i),
    .raddr_i (rd_addr),
    .rdata_o (rd_data)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state_reg  <= srpf_pkg::SRPF_R_FILL;
      wptr_reg      <= 9'h000;
      ovf_reg       <= 1'b0;
      len_reg       <= 12'h000;
      hptr_reg      <= 9'h000;
      toc_base_reg  <= 9'h000;
      scan_done_reg <= 1'b0;
      more_reg      <= 1'b0;
      dptr_reg      <= 12'h000;
      pos_reg       <= 12'h000;
      endp_reg      <= 12'h000;
      d0pos_reg     <= 12'h000;
      d0f_reg       <= 1'b0;
      ph_reg        <= 1'b0;
      rx_cnt_reg    <= 8'h00;
      req_byte_reg  <= 8'h00;
      req_seen_reg  <= 1'b0;
      rx_ready_o    <= 1'b0;
      rx_bit_o      <= 1'b0;
      rx_bit_valid_o   <= 1'b0;
      rx_frame_start_o <= 1'b0;
      rx_frame_end_o   <= 1'b0;
      rx_frame_ft_o    <= 6'h00;
      rx_cmr_o         <= `SRPF_CMR_NONE;
      rx_cmr_valid_o   <= 1'b0;
    end else if (ce_i) begin
      rx_bit_valid_o   <= 1'b0;
      rx_frame_start_o <= 1'b0;
      rx_frame_end_o   <= 1'b0;
      rx_ready_o       <= rx_en && !(rx_take && rx_byte_last_i) &&
                          (rx_state_reg == srpf_pkg::SRPF_R_FILL);
      case (rx_state_reg)
        srpf_pkg::SRPF_R_FILL: begin
          if (rx_take) begin
            wptr_reg <= wptr_n;
            if (wptr_n == 9'h1FF) ovf_reg <= 1'b1;
            if (rx_byte_last_i) begin
              wptr_reg <= 9'h000;
              ovf_reg  <= 1'b0;
              len_reg  <= {wptr_n, 3'h0};
              if (!ovf_reg) rx_state_reg <= srpf_pkg::SRPF_R_CLASS;
            end
          end
        end
        srpf_pkg::SRPF_R_CLASS: rx_state_reg <= srpf_pkg::SRPF_R_DEC;
        srpf_pkg::SRPF_R_DEC: begin
          d0f_reg <= 1'b0;
          ph_reg  <= 1'b0;
          if (cls[5] && !(len_reg == `SRPF_SPECIAL_LEN && !is_p28)) begin
            rx_state_reg     <= srpf_pkg::SRPF_R_BITS;
            rx_frame_start_o <= 1'b1;
            rx_cnt_reg       <= rx_cnt_reg + 8'h01;
            pos_reg          <= 12'h000;
            endp_reg         <= len_reg;
            rx_frame_ft_o    <= {cls[4], cls[4], cls[3:0]};
            if (cls[4]) begin
              rx_cmr_o       <= rd_data[7:5];
              rx_cmr_valid_o <= 1'b1;
              pos_reg        <= {7'h00, `SRPF_CMR_LEN};
              d0pos_reg      <= cmp_k + 12'h002;
              endp_reg       <= cmp_k + 12'h002;
              d0f_reg        <= 1'b1;
            end
          end else begin
            rx_state_reg  <= srpf_pkg::SRPF_R_HDR;
            hptr_reg      <= 9'h000;
            toc_base_reg  <= 9'h000;
            scan_done_reg <= 1'b0;
          end
        end
        srpf_pkg::SRPF_R_HREAD: rx_state_reg <= srpf_pkg::SRPF_R_HDR;
        srpf_pkg::SRPF_R_HDR: begin
          rx_state_reg <= srpf_pkg::SRPF_R_HREAD;
          if (rx_err_evt) begin
            rx_state_reg <= srpf_pkg::SRPF_R_FILL;
          end else if (!scan_done_reg) begin
            hptr_reg <= hptr_reg + 9'h001;
            if (rd_data[7]) begin
              req_byte_reg <= rd_data;
              req_seen_reg <= 1'b1;
              toc_base_reg <= 9'h001;
            end else if (!rd_data[6]) begin
              scan_done_reg <= 1'b1;
              dptr_reg      <= hpos + 12'h008;
              hptr_reg      <= toc_base_reg;
            end
          end else begin
            rx_state_reg     <= srpf_pkg::SRPF_R_BITS;
            rx_frame_start_o <= 1'b1;
            rx_cnt_reg       <= rx_cnt_reg + 8'h01;
            rx_frame_ft_o    <= rd_data[5:0];
            more_reg         <= rd_data[6];
            pos_reg          <= dptr_reg;
            endp_reg         <= toc_end;
            dptr_reg         <= toc_end;
            ph_reg           <= 1'b0;
          end
        end
        srpf_pkg::SRPF_R_BITS: begin
          ph_reg <= !ph_reg;
          if (!ph_reg && bit_end) begin
            // trailing padding after the last frame is never read
            rx_frame_end_o <= 1'b1;
            ph_reg         <= 1'b0;
            hptr_reg       <= hptr_reg + 9'h001;
            rx_state_reg   <= more_reg ? srpf_pkg::SRPF_R_HREAD :
                              srpf_pkg::SRPF_R_FILL;
            more_reg       <= 1'b0;
          end else if (ph_reg) begin
            rx_bit_o       <= rd_data[3'h7 - cur[2:0]];
            rx_bit_valid_o <= 1'b1;
            if (d0f_reg) d0f_reg <= 1'b0;
            else pos_reg <= pos_reg + 12'h001;
          end
        end
        default: rx_state_reg <= srpf_pkg::SRPF_R_FILL;
      endcase
    end
  end

endmodule // srpf_framer

/* File: dv/srpf_monitor.sv */
// port assertions for the payload framer
`timescale 1ns/1ps
module srpf_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic tx_byte_valid_o,
  input wire logic tx_byte_last_o,
  input wire logic rx_ready_o,
  input wire logic rx_bit_valid_o,
  input wire logic rx_frame_start_o,
  input wire logic rx_cmr_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ========
  // checks
  chk_ack_single: assert property (ce_i && wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  chk_ack_next: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack missing");
  chk_last_valid: assert property (tx_byte_last_o |-> tx_byte_valid_o)
    else $error("last without byte");
  chk_payload_gap: assert property (tx_byte_last_o
    |=> !tx_byte_valid_o[*3]) else $error("byte after last");
  chk_bit_gap: assert property (rx_bit_valid_o |=> !rx_bit_valid_o)
    else $error("bits too close");
  chk_start_alone: assert property (rx_frame_start_o
    |-> !rx_bit_valid_o) else $error("start with bit");
  chk_cmr_kept: assert property (rx_cmr_valid_o |=> rx_cmr_valid_o)
    else $error("request lost");
  chk_busy_parse: assert property (rx_bit_valid_o |-> !rx_ready_o)
    else $error("ready while parsing");
endmodule // srpf_monitor

/* File: dv/srpf_endpoint.sv */
// far endpoint: keeps sent payload, returns it on request
`timescale 1ns/1ps
module srpf_endpoint (
  input  wire logic       clk_i,
  input  wire logic       send_i,
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       tx_byte_valid_i,
  input  wire logic       rx_ready_i,
  output logic      [7:0] rx_byte_o,
  output logic            rx_byte_valid_o,
  output logic            rx_byte_last_o,
  output int              n_o
);
  logic [7:0] mem [0:63];
  initial n_o = 0;
  initial rx_byte_o = 8'hA5;
  initial rx_byte_valid_o = 1'b0;
  initial rx_byte_last_o = 1'b0;
  always @(posedge clk_i) if (tx_byte_valid_i) begin
    mem[n_o] <= tx_byte_i;
    n_o <= n_o + 1;
  end
  // each byte held until taken; released lines show the inverse
  always @(posedge send_i) begin
    for (int i = 0; i < n_o; i++) begin
      rx_byte_o <= mem[i];
      rx_byte_valid_o <= 1'b1;
      rx_byte_last_o <= (i == n_o - 1);
      do @(posedge clk_i); while (rx_ready_i !== 1'b1);
    end
    rx_byte_valid_o <= 1'b0;
    rx_byte_last_o <= 1'b0;
    rx_byte_o <= ~rx_byte_o;
  end
endmodule // srpf_endpoint

/* File: dv/speech_rtp_payload_framer_test.sv */
// self-checking bench for the payload framer
`timescale 1ns/1ps
module speech_rtp_payload_framer_test;
  logic clk_i = 0, rst_i = 1, ce_i = 1, wb_cyc_i = 0, wb_stb_i = 0;
  logic wb_we_i = 0, tx_start_i = 0, tx_bit_i = 0, tx_bit_valid_i = 0;
  logic tx_bit_last_i = 0, send = 0;
  logic [7:0] wb_adr_i = 8'h00, tx_byte_o, rx_byte_i;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
  logic [5:0] tx_ft_i = 6'h00, rx_frame_ft_o;
  logic [2:0] rx_cmr_o;
  logic wb_ack_o, tx_ready_o, tx_byte_valid_o, tx_byte_last_o, rx_ready_o;
  logic rx_byte_valid_i, rx_byte_last_i, rx_bit_o, rx_bit_valid_o;
  logic rx_frame_start_o, rx_frame_end_o, rx_cmr_valid_o;
  int n_fail = 0, checked = 0, nb = 0, nbytes;
  srpf_framer srpf_framer_inst (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .tx_start_i, .tx_ft_i, .tx_bit_i, .tx_bit_valid_i, .tx_bit_last_i,
    .tx_ready_o, .tx_byte_o, .tx_byte_valid_o, .tx_byte_last_o, .rx_byte_i,
    .rx_byte_valid_i, .rx_byte_last_i, .rx_ready_o, .rx_bit_o,
    .rx_bit_valid_o, .rx_frame_start_o, .rx_frame_end_o, .rx_frame_ft_o,
    .rx_cmr_o, .rx_cmr_valid_o);
  srpf_endpoint srpf_endpoint_inst (.clk_i, .send_i(send),
    .tx_byte_i(tx_byte_o), .tx_byte_valid_i(tx_byte_valid_o),
    .rx_ready_i(rx_ready_o), .rx_byte_o(rx_byte_i),
    .rx_byte_valid_o(rx_byte_valid_i), .rx_byte_last_o(rx_byte_last_i),
    .n_o(nbytes));
  always #4 clk_i = ~clk_i;
  // ========
  // tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // 132 bits of 6.6, d(i) = i[0], d(0) first
  task automatic feed(input logic [5:0] f);
    tx_ft_i <= f;
    tx_start_i <= 1'b1;
    @(posedge clk_i);
    tx_start_i <= 1'b0;
    for (int i = 0; i < 132; i++) begin
      tx_bit_i <= i[0];
      tx_bit_valid_i <= 1'b1;
      tx_bit_last_i <= (i == 131);
      do @(posedge clk_i); while (tx_ready_o !== 1'b1);
    end
    tx_bit_valid_i <= 1'b0;
    tx_bit_last_i <= 1'b0;
    repeat (20) @(posedge clk_i);
  endtask
  always @(posedge clk_i) if (rx_bit_valid_o === 1'b1) begin
    cmp(32'(rx_bit_o), 32'(nb[0]));
    nb++;
  end
  task automatic test_regs;
    bus(8'h00, 0, 0);
    cmp(rdat, 32'h000000F0);
    bus(8'h04, 0, 0);
    cmp(rdat, 32'h000001FF);
    bus(8'h40, 1, 32'hFFFFFFFF);
    bus(8'h40, 0, 0);
    cmp(rdat, 32'h0);
    bus(8'h00, 1, 32'h00000003);
    $display("regs done");
  endtask
  task automatic test_drop;
    feed(6'h20);
    cmp(32'(nbytes), 32'h0);
    bus(8'h0C, 0, 0);
    cmp(rdat, 32'h00000001);
    $display("drop done");
  endtask
  task automatic test_compact;
    feed(6'h30);
    cmp(32'(nbytes), 32'h11);
    cmp(32'(srpf_endpoint_inst.mem[0]), 32'h15);
    cmp(32'(srpf_endpoint_inst.mem[16]), 32'h54);
    $display("compact done");
  endtask
  task automatic test_loop;
    nb = 0;
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    do @(posedge clk_i); while (rx_frame_end_o !== 1'b1);
    cmp(32'(nb), 32'h84);
    cmp(32'(rx_cmr_o), 32'h0);
    cmp(32'(rx_frame_ft_o), 32'h30);
    $display("loop done");
  endtask
  task automatic report_and_stop;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    test_regs;
    test_drop;
    test_compact;
    test_loop;
    report_and_stop;
  end
  initial begin
    #100us;
    n_fail++;
    report_and_stop;
  end
endmodule // speech_rtp_payload_framer_test
bind srpf_framer srpf_monitor srpf_monitor_inst (.clk_i, .rst_i, .ce_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .tx_byte_valid_o, .tx_byte_last_o,
  .rx_ready_o, .rx_bit_valid_o, .rx_frame_start_o, .rx_cmr_valid_o);
